// file: frw_core.sv
// serial command logic for register write and burst wrap setting
`timescale 1ns/1ps
`default_nettype none
`include "frw_defines.svh"
// Behaviour
// - register write is opcode, 3 or 4 address bytes, one data byte.
// - register write refused unless write enable latch was set before.
// - read-only bits stay unchanged and raise no error.
// - otp bits only leave their default; return attempts ignored silently.
// - changed non-volatile bits take erase plus program over nv write time.
// - erase or program failure sets its error bit and write in progress.
// - changed volatile bits update within volatile write time of select release; here one 100 ns clock after the release is seen.
// - progress in status bit 0, errors in status bits 6 and 5.
// - clear status clears errors and returns to standby.
// - register write never changes the protection lock register.
// - register write framed like single-byte page program.
// - set burst length writes volatile config register 4.
// - wrap applies to quad and ddr quad reads, serial or quad mode.
// - wrap disable one gives unlimited sequential reads.
// - wrap disable zero gives aligned fixed-length wrapping groups.
// - wrap field selects 8, 16, 32 or 64 byte groups.
// - first byte is addressed one, then increment and wrap until deselect.
// - reset loads burst setting from non-volatile config register 4.
// - address length bit set by enter-4-byte, cleared only by reset.
module frw_core #(
  parameter int NV_WRITE_CYCLES = `FRW_NV_WRITE_TIME_US * 1000 / `FRW_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic erase_fail,
  input wire logic program_fail,
  input wire logic read_start,
  input wire logic [7:0] read_cmd,
  input wire logic [31:0] read_start_addr,
  input wire logic read_step,
  output logic [31:0] read_addr,
  output logic [7:0] status_reg1,
  output logic [7:0] config_reg2,
  output logic [7:0] config_reg4,
  output logic [7:0] nv_config_reg4,
  output logic wrap_enable,
  output logic [6:0] wrap_bytes,
  output frw_pkg::frw_state_t op_state
);
  import frw_pkg::*;

  localparam int VOL_CYC_RAW = `FRW_VOL_WRITE_TIME_NS / `FRW_CLK_PERIOD_NS;
  localparam int VOL_WRITE_CYCLES = (VOL_CYC_RAW < 1) ? 1 : VOL_CYC_RAW;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
    input logic [7:0] ro, input logic [7:0] otp);
    logic [7:0] otp_take;
    otp_take = otp & (new_v ^ `FRW_OTP_DEFAULT);
    merge_bits = (old_v & ro) | (new_v & ~ro & ~otp) | (old_v & otp) | otp_take;
  endfunction : merge_bits

  function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic wrap,
    input logic [1:0] len);
    logic [31:0] m;
    m = (32'h0000_0008 << len) - 32'h0000_0001;
    wrap_next = wrap ? ((a & ~m) | ((a + 32'h0000_0001) & m)) : (a + 32'h0000_0001);
  endfunction : wrap_next

  function automatic logic is_wrap_read(input logic [7:0] op);
    is_wrap_read = (op == `FRW_OP_QUAD_READ) || (op == `FRW_OP_QUAD_READ_4B) ||
                   (op == `FRW_OP_DDR_QUAD_READ) || (op == `FRW_OP_DDR_QUAD_READ_4B);
  endfunction : is_wrap_read

  // ************************************************************
  // pin synchronisers and edges
  // ************************************************************
  logic sck_s1, sck_s2, sck_q;
  logic cs_s1, cs_s2, cs_q;
  logic si_s1, si_s2;
  always_ff @(posedge clk)
  begin
    sck_s1 <= sck;
    sck_s2 <= sck_s1;
    cs_s1 <= cs_n;
    cs_s2 <= cs_s1;
    si_s1 <= si;
    si_s2 <= si_s1;
    if (rst)
    begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      sck_q <= sck_s2;
      cs_q <= cs_s2;
    end
  end

  logic sck_rise, frame_start, frame_end;
  assign sck_rise = sck_s2 & ~sck_q & ~cs_s2;
  assign frame_start = ~cs_s2 & cs_q;
  assign frame_end = cs_s2 & ~cs_q;

  // ************************************************************
  // frame capture
  // ************************************************************
  logic [5:0] bit_cnt;
  logic [7:0] opcode;
  logic [39:0] shreg;
  always_ff @(posedge clk)
  begin
    if (rst || frame_start)
    begin
      bit_cnt <= 6'h00;
      opcode <= 8'h00;
      shreg <= 40'h00_0000_0000;
    end
    else if (sck_rise)
    begin
      if (bit_cnt != 6'h3f)
        bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt < 6'h08)
        opcode <= {opcode[6:0], si_s2};
      else
        shreg <= {shreg[38:0], si_s2};
    end
  end

  // ************************************************************
  // command decode at select release
  // ************************************************************
  logic addr4;
  logic [5:0] wr_bits;
  logic [31:0] wr_addr;
  logic [7:0] wr_data;
  logic busy;
  assign addr4 = config_reg2[`FRW_CR2_ADDR4];
  assign wr_bits = addr4 ? 6'h30 : 6'h28;
  assign wr_addr = addr4 ? shreg[39:8] : {8'h00, shreg[31:8]};
  assign wr_data = shreg[7:0];
  assign busy = (op_state != FRW_IDLE);

  logic cmd_write_enable_cmd, cmd_generic_register_write_cmd, cmd_sbl, cmd_clsr, cmd_4byte;
  assign cmd_write_enable_cmd = frame_end && opcode == `FRW_OP_WRITE_ENABLE && bit_cnt == 6'h08 && !busy;
  assign cmd_generic_register_write_cmd = frame_end && opcode == `FRW_OP_REG_WRITE && bit_cnt == wr_bits && !busy &&
                    status_reg1[`FRW_SR1_WEL];
  assign cmd_sbl = frame_end && opcode == `FRW_OP_SET_BURST && bit_cnt == 6'h10 && !busy;
  assign cmd_clsr = frame_end && opcode == `FRW_OP_CLEAR_STATUS && bit_cnt == 6'h08;
  assign cmd_4byte = frame_end && opcode == `FRW_OP_ENTER_4BYTE && bit_cnt == 6'h08 && !busy;

  logic [7:0] nonvolatile_config_reg4_merged;
  logic nv_change;
  assign nonvolatile_config_reg4_merged = merge_bits(nv_config_reg4, wr_data, `FRW_CR4_RO_MASK,
                                   `FRW_CR4_OTP_MASK);
  assign nv_change = cmd_generic_register_write_cmd && wr_addr == `FRW_ADDR_NONVOLATILE_CONFIG_REG4 &&
                     nonvolatile_config_reg4_merged != nv_config_reg4;

  // ************************************************************
  // non-volatile operation sequencer
  // ************************************************************
  logic [31:0] nv_cnt;
  logic [7:0] nv_pending;
  logic nv_done, nv_fail_e, nv_fail_p;
  assign nv_done = (op_state == FRW_NV_BUSY) && nv_cnt == 32'(NV_WRITE_CYCLES - 1);
  assign nv_fail_e = nv_done && erase_fail;
  assign nv_fail_p = nv_done && program_fail && !erase_fail;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_state <= FRW_IDLE;
      nv_cnt <= 32'h0000_0000;
      nv_pending <= 8'h00;
    end
    else
    begin
      unique case (op_state)
        FRW_IDLE:
        begin
          nv_cnt <= 32'h0000_0000;
          if (nv_change)
          begin
            op_state <= FRW_NV_BUSY;
            nv_pending <= nonvolatile_config_reg4_merged;
          end
        end
        FRW_NV_BUSY:
        begin
          nv_cnt <= nv_cnt + 32'h0000_0001;
          if (nv_done)
            op_state <= (erase_fail || program_fail) ? FRW_FAILED : FRW_IDLE;
        end
        FRW_FAILED:
        begin
          if (cmd_clsr)
            op_state <= FRW_IDLE;
        end
        default:
          op_state <= FRW_IDLE;
      endcase
    end
  end

  // cell keeps its content through reset; only a good write changes it
  logic [7:0] nv_cell = `FRW_NONVOLATILE_CONFIG_REG4_RESET;
  assign nv_config_reg4 = nv_cell;
  always_ff @(posedge clk)
  begin
    if (nv_done && !erase_fail && !program_fail)
      nv_cell <= nv_pending;
  end

  // ************************************************************
  // status register 1
  // ************************************************************
  logic write_enable_latch, e_err, p_err;
  always_ff @(posedge clk)
  begin
    if (rst)
      write_enable_latch <= 1'b0;
    else if (cmd_write_enable_cmd)
      write_enable_latch <= 1'b1;
    else if (cmd_generic_register_write_cmd && !nv_change)
      write_enable_latch <= 1'b0;
    else if (nv_done && !erase_fail && !program_fail)
      write_enable_latch <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      e_err <= 1'b0;
      p_err <= 1'b0;
    end
    else
    begin
      if (nv_fail_e)
        e_err <= 1'b1;
      else if (cmd_clsr)
        e_err <= 1'b0;
      if (nv_fail_p)
        p_err <= 1'b1;
      else if (cmd_clsr)
        p_err <= 1'b0;
    end
  end

  always_comb
  begin
    status_reg1 = 8'h00;
    status_reg1[`FRW_SR1_WIP] = busy;
    status_reg1[`FRW_SR1_WEL] = write_enable_latch;
    status_reg1[`FRW_SR1_E_ERR] = e_err;
    status_reg1[`FRW_SR1_P_ERR] = p_err;
  end

  // ************************************************************
  // volatile configuration registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      config_reg2 <= `FRW_CR2_RESET;
    else if (cmd_4byte)
      config_reg2[`FRW_CR2_ADDR4] <= 1'b1;
    else if (cmd_generic_register_write_cmd && wr_addr == `FRW_ADDR_VOLATILE_CONFIG_REG2)
      config_reg2 <= merge_bits(config_reg2, wr_data, `FRW_CR2_RO_MASK,
                                `FRW_CR2_OTP_MASK);
  end

  // volatile update lands VOL_WRITE_CYCLES after the release is seen
  logic [7:0] volatile_config_reg4_next;
  logic volatile_config_reg4_load;
  always_comb
  begin
    volatile_config_reg4_load = 1'b0;
    volatile_config_reg4_next = config_reg4;
    if (cmd_sbl)
    begin
      volatile_config_reg4_load = 1'b1;
      volatile_config_reg4_next = (config_reg4 & ~`FRW_CR4_SBL_MASK) |
                  (wr_data & `FRW_CR4_SBL_MASK);
    end
    else if (cmd_generic_register_write_cmd && wr_addr == `FRW_ADDR_VOLATILE_CONFIG_REG4)
    begin
      volatile_config_reg4_load = 1'b1;
      volatile_config_reg4_next = merge_bits(config_reg4, wr_data, `FRW_CR4_RO_MASK,
                             `FRW_CR4_OTP_MASK);
    end
    // protection lock address deliberately matches nothing here
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      config_reg4 <= nv_config_reg4;
    else if (volatile_config_reg4_load && VOL_WRITE_CYCLES >= 1)
      config_reg4 <= volatile_config_reg4_next;
  end

  // ************************************************************
  // burst wrap address sequencer
  // ************************************************************
  logic rd_wrap;
  assign wrap_enable = ~config_reg4[`FRW_CR4_WRAP_DIS];
  assign wrap_bytes = 7'(`FRW_WRAP_BASE_BYTES)
                      << config_reg4[`FRW_CR4_WRAP_LEN_HI:`FRW_CR4_WRAP_LEN_LO];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      read_addr <= 32'h0000_0000;
      rd_wrap <= 1'b0;
    end
    else if (read_start)
    begin
      read_addr <= read_start_addr;
      rd_wrap <= is_wrap_read(read_cmd) && wrap_enable;
    end
    else if (read_step)
      read_addr <= wrap_next(read_addr, rd_wrap,
        config_reg4[`FRW_CR4_WRAP_LEN_HI:`FRW_CR4_WRAP_LEN_LO]);
  end
endmodule : frw_core
`default_nettype wire

// file: frw_defines.svh
// constants of the flash register write and burst wrap command logic
`ifndef FRW_DEFINES_SVH
`define FRW_DEFINES_SVH
// ************************************************************
// command codes
// ************************************************************
`define FRW_OP_WRITE_ENABLE 8'h06
`define FRW_OP_REG_WRITE 8'h71
`define FRW_OP_SET_BURST 8'hc0
`define FRW_OP_CLEAR_STATUS 8'h30
`define FRW_OP_ENTER_4BYTE 8'hb7
`define FRW_OP_QUAD_READ 8'heb
`define FRW_OP_QUAD_READ_4B 8'hec
`define FRW_OP_DDR_QUAD_READ 8'hed
`define FRW_OP_DDR_QUAD_READ_4B 8'hee
// ************************************************************
// register addresses
// ************************************************************
`define FRW_ADDR_NONVOLATILE_CONFIG_REG4 32'h0000_0005
`define FRW_ADDR_VOLATILE_CONFIG_REG2 32'h0080_0003
`define FRW_ADDR_VOLATILE_CONFIG_REG4 32'h0080_0005
`define FRW_ADDR_PROTECTION_LOCK_REG 32'h0080_0040
// ************************************************************
// field positions
// ************************************************************
`define FRW_SR1_WIP 0
`define FRW_SR1_WEL 1
`define FRW_SR1_E_ERR 5
`define FRW_SR1_P_ERR 6
`define FRW_CR2_ADDR4 7
`define FRW_CR4_WRAP_DIS 4
`define FRW_CR4_WRAP_LEN_HI 1
`define FRW_CR4_WRAP_LEN_LO 0
// ************************************************************
// bit types and reset values
// ************************************************************
`define FRW_CR4_RO_MASK 8'h0c
`define FRW_CR4_OTP_MASK 8'h00
`define FRW_CR4_SBL_MASK 8'h13
`define FRW_CR2_RO_MASK 8'h00
`define FRW_CR2_OTP_MASK 8'h80
`define FRW_CR2_RESET 8'h08
`define FRW_NONVOLATILE_CONFIG_REG4_RESET 8'h10
`define FRW_OTP_DEFAULT 8'h00
// ************************************************************
// timing
// ************************************************************
`define FRW_CLK_PERIOD_NS 100
`define FRW_NV_WRITE_TIME_US 1000
`define FRW_VOL_WRITE_TIME_NS 50
`define FRW_WRAP_BASE_BYTES 8
`endif

// file: frw_pkg.sv
// types of the flash register write and burst wrap command logic
`default_nettype none
package frw_pkg;
  typedef enum logic [2:0]
  {
    FRW_IDLE = 3'b001,
    FRW_NV_BUSY = 3'b010,
    FRW_FAILED = 3'b100
  } frw_state_t;
endpackage : frw_pkg
`default_nettype wire

// file: frw_core_asserts.sv
// checker of the register write and burst wrap logic
`timescale 1ns/1ps
`default_nettype none
module frw_core_asserts #(
  parameter int NV_WRITE_CYCLES = 10000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic read_start,
  input wire logic [31:0] read_start_addr,
  input wire logic [31:0] read_addr,
  input wire logic [7:0] status_reg1,
  input wire logic [7:0] config_reg2,
  input wire logic [7:0] config_reg4,
  input wire logic [7:0] nv_config_reg4,
  input wire logic wrap_enable,
  input wire logic [6:0] wrap_bytes,
  input wire frw_pkg::frw_state_t op_state
);
  import frw_pkg::*;
  int busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ********
  // assertions
  // ********
  always_ff @(posedge clk)
    if (rst || op_state != FRW_NV_BUSY)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  wrap_mode_a: assert property (wrap_enable == !config_reg4[4])
    else $error("wrap enable wrong");
  wrap_size_a: assert property (wrap_bytes == (7'h08 << config_reg4[1:0]))
    else $error("wrap size wrong");
  busy_flag_a: assert property (op_state == FRW_NV_BUSY |-> status_reg1[0])
    else $error("busy without progress flag");
  fail_flags_a: assert property (op_state == FRW_FAILED |-> status_reg1[0] && |status_reg1[6:5])
    else $error("failure flags missing");
  busy_bound_a: assert property (busy_cnt <= NV_WRITE_CYCLES + 1)
    else $error("nonvolatile write too long");
  ro_bits_a: assert property ($stable(config_reg4[3:2]))
    else $error("read-only bits moved");
  addr_mode_a: assert property (!$fell(config_reg2[7]))
    else $error("address length bit cleared");
  nv_update_a: assert property ($changed(nv_config_reg4) |-> $past(op_state) == FRW_NV_BUSY)
    else $error("nonvolatile change outside write");
  read_first_a: assert property (read_start |=> read_addr == $past(read_start_addr))
    else $error("first read address wrong");
  spare_bits_a: assert property (status_reg1[4:2] == 3'b000 && !status_reg1[7])
    else $error("unused status bits set");
endmodule : frw_core_asserts
`default_nettype wire

// file: frw_host_model.sv
// serial host model that frames commands
`timescale 1ns/1ps
`default_nettype none
module frw_host_model (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic si
);
  // ********
  // serial framing
  // ********
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask : half
  // whole bytes msb first, clock idle low outside frames
  task automatic frame(input logic [7:0] q[$]);
    cs_n = 1'b0;
    foreach (q[i])
      for (int b = 7; b >= 0; b--)
      begin
        si = q[i][b];
        half();
        sck = 1'b1;
        half();
        sck = 1'b0;
      end
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask : frame
endmodule : frw_host_model
`default_nettype wire

// file: frw_core_bench.sv
// bench for the register write and burst wrap logic
`timescale 1ns/1ps
`default_nettype none
`include "frw_defines.svh"
module frw_core_bench;
  import frw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic erase_fail = 1'b0;
  logic program_fail = 1'b0;
  logic read_start = 1'b0;
  logic read_step = 1'b0;
  logic [7:0] read_cmd = 8'h03;
  logic [31:0] read_start_addr = 32'h0;
  logic sck, cs_n, si, wrap_enable;
  logic [31:0] read_addr;
  logic [7:0] status_reg1, config_reg2, config_reg4, nv_config_reg4;
  logic [6:0] wrap_bytes;
  frw_state_t op_state;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h28dc3ff5;
  logic [7:0] e2 = 8'h08, e4 = 8'h10, env = 8'h10;
  logic [7:0] ops[5] = '{8'heb, 8'hec, 8'hed, 8'hee, 8'h0b};
  always #50 clk = ~clk;
  frw_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si));
  frw_core #(.NV_WRITE_CYCLES(20)) DUT (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .erase_fail(erase_fail), .program_fail(program_fail), .read_start(read_start),
    .read_cmd(read_cmd), .read_start_addr(read_start_addr), .read_step(read_step),
    .read_addr(read_addr), .status_reg1(status_reg1), .config_reg2(config_reg2),
    .config_reg4(config_reg4), .nv_config_reg4(nv_config_reg4),
    .wrap_enable(wrap_enable), .wrap_bytes(wrap_bytes), .op_state(op_state));
  // ********
  // tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic regs();
    chk(config_reg4, e4);
    chk(config_reg2, e2);
    chk(nv_config_reg4, env);
    chk(status_reg1, 8'h00);
    chk(wrap_enable, !e4[4]);
    chk(wrap_bytes, 32'h8 << e4[1:0]);
  endtask : regs
  task automatic send(input logic [7:0] q[$]);
    host.frame(q);
    tick(2);
  endtask : send
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    q = {8'h06};
    send(q);
    q = {8'h71, a[23:16], a[15:8], a[7:0], d};
    if (e2[7])
      q.insert(1, a[31:24]);
    send(q);
    case (a)
      `FRW_ADDR_VOLATILE_CONFIG_REG4: e4 = (e4 & 8'h0c) | (d & 8'hf3);
      `FRW_ADDR_VOLATILE_CONFIG_REG2: e2 = (d & 8'h7f) | ((e2 | d) & 8'h80);
      `FRW_ADDR_NONVOLATILE_CONFIG_REG4: if (!erase_fail && !program_fail) env = (env & 8'h0c) | (d & 8'hf3);
      default: ;
    endcase
    if (a == `FRW_ADDR_NONVOLATILE_CONFIG_REG4)
      chk(status_reg1[0], 1'b1);
    for (int i = 0; i < 60 && op_state == FRW_NV_BUSY; i++)
      tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [31:0] a);
    logic [31:0] x, m;
    x = a;
    m = (32'h8 << e4[1:0]) - 1;
    read_cmd = c;
    read_start_addr = a;
    read_start = 1'b1;
    tick(1);
    read_start = 1'b0;
    read_step = 1'b1;
    chk(read_addr, x);
    repeat (20)
    begin
      tick(1);
      x = (!e4[4] && c[7:4] == 4'he) ? (x & ~m) | ((x + 1) & m) : x + 1;
      chk(read_addr, x);
    end
    read_step = 1'b0;
    tick(1);
  endtask : rd
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ********
  // stimulus and checks
  // ********
  initial
  begin
    logic [7:0] q[$];
    logic [7:0] d;
    tick(10);
    rst = 1'b0;
    tick(4);
    regs();
    q = {8'h71, 8'h80, 8'h00, 8'h05, 8'h5a};
    send(q);
    regs();
    repeat (4)
    begin
      wr(`FRW_ADDR_VOLATILE_CONFIG_REG4, 8'($random(seed)));
      regs();
    end
    wr(`FRW_ADDR_PROTECTION_LOCK_REG, 8'hff);
    regs();
    for (int k = 0; k < 5; k++)
    begin
      d = (8'($random(seed)) & 8'hec) | ((k == 4) ? 8'h10 : 8'(k));
      q = {8'hc0, d};
      send(q);
      e4 = (e4 & 8'hec) | (d & 8'h13);
      regs();
      foreach (ops[j])
        rd(ops[j], $random(seed));
    end
    wr(`FRW_ADDR_VOLATILE_CONFIG_REG2, 8'h88);
    wr(`FRW_ADDR_NONVOLATILE_CONFIG_REG4, 8'h01);
    regs();
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(4);
    e4 = env;
    e2 = 8'h08;
    regs();
    q = {8'hb7};
    send(q);
    e2[7] = 1'b1;
    wr(`FRW_ADDR_VOLATILE_CONFIG_REG2, 8'h08);
    regs();
    for (int f = 0; f < 2; f++)
    begin
      {erase_fail, program_fail} = f ? 2'b01 : 2'b10;
      wr(`FRW_ADDR_NONVOLATILE_CONFIG_REG4, f ? 8'h03 : 8'h10);
      chk(op_state, FRW_FAILED);
      chk(status_reg1 & 8'h61, f ? 8'h41 : 8'h21);
      chk(nv_config_reg4, env);
      {erase_fail, program_fail} = 2'b00;
      q = {8'h30};
      send(q);
      chk(status_reg1 & 8'h61, 8'h00);
      chk(op_state, FRW_IDLE);
    end
    conclude();
  end
endmodule : frw_core_bench
bind frw_core frw_core_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_i (.clk(clk), .rst(rst),
  .read_start(read_start), .read_start_addr(read_start_addr), .read_addr(read_addr),
  .status_reg1(status_reg1), .config_reg2(config_reg2), .config_reg4(config_reg4),
  .nv_config_reg4(nv_config_reg4), .wrap_enable(wrap_enable), .wrap_bytes(wrap_bytes),
  .op_state(op_state));
`default_nettype wire
